// ==== common/lgam_pkg.sv ====
// constants, register map and types of the local-to-global address mapper
// assumes a 32-bit Avalon-MM register bus with byte addresses
package lgam_pkg;

  // ************************************************************
  // address widths
  // ************************************************************
  localparam int LOCAL_AW = 16;
  localparam int GLOBAL_AW = 23;
  localparam int AVS_AW = 8;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_MAP_CONTROL_ZERO = 6'h0A;
  localparam logic [5:0] IDX_EXT_BUS_CONTROL_ZERO = 6'h0E;
  localparam logic [5:0] IDX_GLOBAL_PAGE = 6'h10;
  localparam logic [5:0] IDX_MAP_CONTROL_ONE = 6'h13;
  localparam logic [5:0] IDX_FLASH_WINDOW_PAGE = 6'h15;
  localparam logic [5:0] IDX_RAM_WINDOW_PAGE = 6'h16;
  localparam logic [5:0] IDX_MAP_STATUS = 6'h17;
  localparam logic [5:0] IDX_RESERVED_OLD_PAGE = 6'h30;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int FLASH_HIGH_MAP_POS = 1;
  localparam int RAM_HIGH_MAP_POS = 3;
  localparam int STAT_ALT_ACTIVE_POS = 0;
  localparam int STAT_ONCE_USED_POS = 1;
  localparam int STRETCH_CNT_W = 4;
  localparam logic [7:0] FLASH_WINDOW_PAGE_RST = 8'hFE;
  localparam logic [7:0] RAM_WINDOW_PAGE_RST = 8'hFD;
  localparam logic [7:0] GLOBAL_PAGE_RST = 8'h00;
  localparam logic [7:0] MAP_CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] MAP_CONTROL_ZERO_RST = 8'h00;
  localparam logic [7:0] EXT_BUS_CONTROL_ZERO_RST = 8'h00;

  // ************************************************************
  // memory map figures
  // ************************************************************
  localparam logic [7:0] FIXED_LOW_FLASH_PAGE = 8'hFD;
  localparam logic [7:0] FIXED_TOP_FLASH_PAGE = 8'hFF;
  localparam logic [GLOBAL_AW-1:0] FLASH_BASE = 23'h40_0000;
  localparam logic [GLOBAL_AW-1:0] FLASH_TOP = 23'h7F_FFFF;
  localparam logic [GLOBAL_AW-1:0] ALT_RAM_LOW_BASE = 23'h0F_A000;
  localparam logic [GLOBAL_AW-1:0] ALT_RAM_HIGH_BASE = 23'h0F_C000;
  localparam logic [GLOBAL_AW-1:0] FIXED_RAM_BASE = 23'h0F_E000;
  localparam logic [GLOBAL_AW-1:0] RAM_REGION_BASE = 23'h00_0000;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    LGAM_STRETCH_NONE,
    LGAM_STRETCH_CNT_A,
    LGAM_STRETCH_CNT_B,
    LGAM_STRETCH_EXTERNAL_WAIT_INPUT
  } lgam_stretch_t;

  typedef enum logic [1:0] {
    LGAM_REG_OTHER,
    LGAM_REG_RAM,
    LGAM_REG_FLASH,
    LGAM_REG_GLOBAL
  } lgam_region_t;

endpackage

// ==== common/lgam_cs_if.sv ====
// bundle between the mapper core and one chip select stretch selector
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface lgam_cs_if;
  import lgam_pkg::*;
  logic [1:0] sel;
  logic [STRETCH_CNT_W-1:0] cnt_a;
  logic [STRETCH_CNT_W-1:0] cnt_b;
  logic [STRETCH_CNT_W-1:0] cnt;
  logic wait_en;

  modport ctl (output sel, output cnt_a, output cnt_b, input cnt, input wait_en);
  modport selp (input sel, input cnt_a, input cnt_b, output cnt, output wait_en);
endinterface

// ==== design/lgam_cs_stretch.sv ====
// stretch source selection for one external chip select
// assumes sel and counts come from software registers in the same clock domain
`timescale 1ns/1ps
module lgam_cs_stretch (
  input wire logic i_clk,
  input wire logic i_resetn,
  lgam_cs_if.selp cs
);
  import lgam_pkg::*;

  lgam_stretch_t src;
  assign src = lgam_stretch_t'(cs.sel);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs.cnt <= '0;
      cs.wait_en <= 1'b0;
    end else begin
      unique case (src)
        LGAM_STRETCH_NONE: begin
          cs.cnt <= '0;
          cs.wait_en <= 1'b0;
        end
        LGAM_STRETCH_CNT_A: begin
          cs.cnt <= cs.cnt_a;
          cs.wait_en <= 1'b0;
        end
        LGAM_STRETCH_CNT_B: begin
          cs.cnt <= cs.cnt_b;
          cs.wait_en <= 1'b0;
        end
        LGAM_STRETCH_EXTERNAL_WAIT_INPUT: begin
          cs.cnt <= '0;
          cs.wait_en <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== design/lgam_mapper.sv ====
// local-to-global address mapper with paging registers and chip select
// stretch selection, registers reached over Avalon-MM with waitrequest
// assumes the cpu address inputs are synchronous to I_SYS_CLK
//
// Overview of operation
// - flash occupies global 0x40_0000 to 0x7F_FFFF, at most 4 Mbytes
// - local 0x8000-0xBFFF reaches the 16K flash page named by the window page
// - flash pages are linear: page 0x00 at 0x40_0000, 16K per step to 0xFF
// - local 0x4000-0x7FFF maps to global flash 0x7F_4000, page register ignored
// - local 0xC000-0xFFFF always maps to global flash 0x7F_C000-0x7F_FFFF
// - window page 0xFD shows the same flash page fixed at local 0x4000
// - global accesses see one linear 8 Mbyte space through the global page
// - flash window page decodes at register index 0x15; index 0x30 is reserved
// - alternative ram mapping selection accepts one write after reset only
// - alternative mapping active only when ram and flash high map bits are set
// - alternative mapping sends local 0x4000-0x7FFF to ram 0x0F_C000-0x0F_FFFF
// - alternative mapping sends local 0x2000-0x3FFF to ram 0x0F_A000-0x0F_BFFF
// - ram window page resets to 0xFD; software may write 0xF9 for flat ram
// - with alternative mapping, flash page 0xFD stays reachable paged and global
// - each chip select picks count a, count b or external wait by two bits
// - global address top seven bits come from global page bits 6:0 on global accesses
// - local 0x1000-0x1FFF is a 4K ram window; 0x2000-0x3FFF is fixed ram
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module lgam_mapper #(
  parameter int NUM_CS = 4
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic [lgam_pkg::AVS_AW-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_CPU_REQ,
  input wire logic I_CPU_GLOBAL,
  input wire logic [lgam_pkg::LOCAL_AW-1:0] I_CPU_ADDR,
  output logic O_GLOBAL_VALID,
  output logic [lgam_pkg::GLOBAL_AW-1:0] O_GLOBAL_ADDR,
  output logic [1:0] O_REGION,
  output logic O_ALT_MAP_ACTIVE,
  output logic [NUM_CS*lgam_pkg::STRETCH_CNT_W-1:0] O_CS_STRETCH_CNT,
  output logic [NUM_CS-1:0] O_CS_WAIT_EN
);
  import lgam_pkg::*;

  // ************************************************************
  // parameter check
  // ************************************************************
  // each chip select takes two selector bits of one 8-bit control register
  if (NUM_CS < 1 || NUM_CS > 4) begin : g_bad_cs
    $error("NUM_CS must lie between 1 and 4");
  end

  // both stretch counts share one 8-bit control register
  if (2 * STRETCH_CNT_W > 8) begin : g_bad_cnt_w
    $error("two stretch counts must fit in one byte");
  end

  // the translation concatenations are laid out for these widths
  if (LOCAL_AW != 16 || GLOBAL_AW != 23) begin : g_bad_aw
    $error("address widths must be 16 local and 23 global");
  end

  // the register index is taken from address bits 7:2
  if (AVS_AW != 8) begin : g_bad_avs_aw
    $error("register bus address must be 8 bits wide");
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] flash_window_page_r;
  logic [7:0] ram_window_page_r;
  logic [7:0] global_page_r;
  logic [7:0] map_control_one_r;
  logic [7:0] map_control_zero_r;
  logic [7:0] ext_bus_control_zero_r;
  logic ram_map_once_used_r;
  logic alt_map_active;

  // ************************************************************
  // avalon slave handshake
  // ************************************************************
  logic waitreq_r;
  logic req;
  logic take;
  logic wr_take;
  logic [5:0] idx;
  logic [7:0] rd_byte;

  assign req = I_AVS_READ | I_AVS_WRITE;
  // one wait cycle: data is prepared while waitrequest is high
  assign take = req & ~waitreq_r;
  assign wr_take = take & I_AVS_WRITE & I_AVS_BYTEENABLE[0];
  assign idx = I_AVS_ADDRESS[7:2];

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= ~(req & waitreq_r);
    end
  end

  assign O_AVS_WAITREQUEST = waitreq_r;

  // ************************************************************
  // read decode
  // ************************************************************
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_FLASH_WINDOW_PAGE: begin
        rd_byte = flash_window_page_r;
      end
      IDX_RAM_WINDOW_PAGE: begin
        rd_byte = ram_window_page_r;
      end
      IDX_GLOBAL_PAGE: begin
        rd_byte = global_page_r;
      end
      IDX_MAP_CONTROL_ONE: begin
        rd_byte = map_control_one_r;
      end
      IDX_MAP_CONTROL_ZERO: begin
        rd_byte = map_control_zero_r;
      end
      IDX_EXT_BUS_CONTROL_ZERO: begin
        rd_byte = ext_bus_control_zero_r;
      end
      IDX_MAP_STATUS: begin
        rd_byte[STAT_ALT_ACTIVE_POS] = alt_map_active;
        rd_byte[STAT_ONCE_USED_POS] = ram_map_once_used_r;
      end
      default: begin
        // reserved index 0x30 and all unmapped words read as zero
        rd_byte = 8'h00;
      end
    endcase
  end

  // captured in the wait cycle so the data stands at the answer edge
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (req & waitreq_r & I_AVS_READ) begin
      O_AVS_READDATA <= {24'h00_0000, rd_byte};
    end
  end

  // ************************************************************
  // paging registers
  // ************************************************************
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      flash_window_page_r <= FLASH_WINDOW_PAGE_RST;
    end else if (wr_take && idx == IDX_FLASH_WINDOW_PAGE) begin
      flash_window_page_r <= I_AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ram_window_page_r <= RAM_WINDOW_PAGE_RST;
    end else if (wr_take && idx == IDX_RAM_WINDOW_PAGE) begin
      ram_window_page_r <= I_AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      global_page_r <= GLOBAL_PAGE_RST;
    end else if (wr_take && idx == IDX_GLOBAL_PAGE) begin
      global_page_r <= I_AVS_WRITEDATA[7:0];
    end
  end

  // ************************************************************
  // map control registers
  // ************************************************************
  // the first write after reset, of any value, locks the ram high map bit
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ram_map_once_used_r <= 1'b0;
    end else if (wr_take && idx == IDX_MAP_CONTROL_ONE) begin
      ram_map_once_used_r <= 1'b1;
    end
  end

  // the ram high map bit takes only the first write after reset
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      map_control_one_r <= MAP_CONTROL_ONE_RST;
    end else if (wr_take && idx == IDX_MAP_CONTROL_ONE) begin
      for (int b = 0; b < 8; b++) begin
        if (b != RAM_HIGH_MAP_POS || !ram_map_once_used_r) begin
          map_control_one_r[b] <= I_AVS_WRITEDATA[b];
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      map_control_zero_r <= MAP_CONTROL_ZERO_RST;
    end else if (wr_take && idx == IDX_MAP_CONTROL_ZERO) begin
      map_control_zero_r <= I_AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ext_bus_control_zero_r <= EXT_BUS_CONTROL_ZERO_RST;
    end else if (wr_take && idx == IDX_EXT_BUS_CONTROL_ZERO) begin
      ext_bus_control_zero_r <= I_AVS_WRITEDATA[7:0];
    end
  end

  assign alt_map_active = map_control_one_r[RAM_HIGH_MAP_POS]
                        & map_control_one_r[FLASH_HIGH_MAP_POS];

  // ************************************************************
  // address translation
  // ************************************************************
  logic [GLOBAL_AW-1:0] gaddr_nxt;
  logic [1:0] region_nxt;
  logic [GLOBAL_AW-1:0] flash_off;
  logic [1:0] local_win;

  // flash page p starts at 0x40_0000 + p * 16K
  function automatic logic [GLOBAL_AW-1:0] flash_addr(
    input logic [7:0] page,
    input logic [13:0] off
  );
    flash_addr = FLASH_BASE | {1'b0, page, off};
  endfunction

  assign flash_off = flash_addr(flash_window_page_r, I_CPU_ADDR[13:0]);

  // which 16K quarter of the local map is addressed
  assign local_win = I_CPU_ADDR[15:14];

  always_comb begin
    // below the ram window the local address passes through unchanged
    gaddr_nxt = {7'h00, I_CPU_ADDR};
    region_nxt = LGAM_REG_OTHER;
    if (I_CPU_GLOBAL) begin
      // bit 7 of the global page is dropped: the global space is 8 Mbytes
      gaddr_nxt = {global_page_r[6:0], I_CPU_ADDR};
      region_nxt = LGAM_REG_GLOBAL;
    end else begin
      unique case (local_win)
        2'b00: begin
          if (I_CPU_ADDR[13]) begin
            region_nxt = LGAM_REG_RAM;
            if (alt_map_active) begin
              gaddr_nxt = ALT_RAM_LOW_BASE | {10'h000, I_CPU_ADDR[12:0]};
            end else begin
              gaddr_nxt = FIXED_RAM_BASE | {10'h000, I_CPU_ADDR[12:0]};
            end
          end else if (I_CPU_ADDR[12]) begin
            region_nxt = LGAM_REG_RAM;
            gaddr_nxt = RAM_REGION_BASE
                      | {3'b000, ram_window_page_r, I_CPU_ADDR[11:0]};
          end
        end
        2'b01: begin
          if (alt_map_active) begin
            region_nxt = LGAM_REG_RAM;
            gaddr_nxt = ALT_RAM_HIGH_BASE | {9'h000, I_CPU_ADDR[13:0]};
          end else begin
            region_nxt = LGAM_REG_FLASH;
            gaddr_nxt = flash_addr(FIXED_LOW_FLASH_PAGE, I_CPU_ADDR[13:0]);
          end
        end
        2'b10: begin
          region_nxt = LGAM_REG_FLASH;
          // page 0xFD lands on the fixed low page, also with alternative mapping
          gaddr_nxt = flash_off;
        end
        2'b11: begin
          region_nxt = LGAM_REG_FLASH;
          gaddr_nxt = flash_addr(FIXED_TOP_FLASH_PAGE, I_CPU_ADDR[13:0]);
        end
      endcase
    end
  end

  // valid follows each request cycle by one edge
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_GLOBAL_VALID <= 1'b0;
    end else begin
      O_GLOBAL_VALID <= I_CPU_REQ;
    end
  end

  // address and region hold between requests
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_GLOBAL_ADDR <= '0;
    end else if (I_CPU_REQ) begin
      O_GLOBAL_ADDR <= gaddr_nxt;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_REGION <= LGAM_REG_OTHER;
    end else if (I_CPU_REQ) begin
      O_REGION <= region_nxt;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ALT_MAP_ACTIVE <= 1'b0;
    end else begin
      O_ALT_MAP_ACTIVE <= alt_map_active;
    end
  end

  // ************************************************************
  // chip select stretch selection
  // ************************************************************
  // all chip selects share both counts; two selector bits each choose
  lgam_cs_if cs_if[NUM_CS] ();

  for (genvar g = 0; g < NUM_CS; g++) begin : g_cs
    assign cs_if[g].sel = map_control_zero_r[2*g+1:2*g];
    assign cs_if[g].cnt_a = ext_bus_control_zero_r[STRETCH_CNT_W-1:0];
    assign cs_if[g].cnt_b = ext_bus_control_zero_r[2*STRETCH_CNT_W-1:STRETCH_CNT_W];
    lgam_cs_stretch u_sel (
      .i_clk(I_SYS_CLK),
      .i_resetn(I_RESETN),
      .cs(cs_if[g])
    );
    assign O_CS_STRETCH_CNT[g*STRETCH_CNT_W +: STRETCH_CNT_W] = cs_if[g].cnt;
    assign O_CS_WAIT_EN[g] = cs_if[g].wait_en;
  end

endmodule

// ==== tb/lgam_mapper_monitor.sv ====
// port assertions for the address mapper
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module lgam_mapper_monitor (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_CPU_REQ,
  input wire logic I_CPU_GLOBAL,
  input wire logic [lgam_pkg::LOCAL_AW-1:0] I_CPU_ADDR,
  input wire logic O_GLOBAL_VALID,
  input wire logic [lgam_pkg::GLOBAL_AW-1:0] O_GLOBAL_ADDR,
  input wire logic [1:0] O_REGION,
  input wire logic O_ALT_MAP_ACTIVE
);
  import lgam_pkg::*;
  logic loc;
  logic [15:0] addr_q;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);

  assign loc = I_CPU_REQ && !I_CPU_GLOBAL;
  // request address, kept one cycle for comparison with the answer
  always_ff @(posedge I_SYS_CLK) begin
    addr_q <= I_CPU_ADDR;
  end

  AST_VALID_AFTER_REQ: assert property (I_CPU_REQ |=> O_GLOBAL_VALID)
    else $error("valid missing after request");
  AST_NO_STRAY_VALID: assert property (!I_CPU_REQ |=> !O_GLOBAL_VALID)
    else $error("valid without request");
  AST_HOLD_ADDR: assert property (!I_CPU_REQ |=> $stable(O_GLOBAL_ADDR) && $stable(O_REGION))
    else $error("address changed without request");
  AST_TOP_FIXED: assert property (loc && I_CPU_ADDR[15:14] == 2'h3 |=>
    O_GLOBAL_ADDR == {9'h1FF, addr_q[13:0]} && O_REGION == 2'h2)
    else $error("top fixed flash translation wrong");
  AST_LOW_FIXED: assert property (loc && I_CPU_ADDR[15:14] == 2'h1 && !O_ALT_MAP_ACTIVE |=>
    O_GLOBAL_ADDR == {9'h1FD, addr_q[13:0]} && O_REGION == 2'h2)
    else $error("low fixed flash translation wrong");
  AST_ALT_HIGH: assert property (loc && I_CPU_ADDR[15:14] == 2'h1 && O_ALT_MAP_ACTIVE |=>
    O_GLOBAL_ADDR == {9'h03F, addr_q[13:0]} && O_REGION == 2'h1)
    else $error("alternative high ram translation wrong");
  AST_FIXED_RAM: assert property (loc && I_CPU_ADDR[15:13] == 3'h1 |=>
    O_GLOBAL_ADDR == {($past(O_ALT_MAP_ACTIVE) ? 10'h07D : 10'h07F), addr_q[12:0]})
    else $error("fixed ram translation wrong");
  AST_FLASH_WINDOW: assert property (loc && I_CPU_ADDR[15:14] == 2'h2 |=>
    O_GLOBAL_ADDR[22] && O_GLOBAL_ADDR[13:0] == addr_q[13:0] && O_REGION == 2'h2)
    else $error("flash window translation wrong");
  AST_RAM_WINDOW: assert property (loc && I_CPU_ADDR[15:12] == 4'h1 |=>
    O_GLOBAL_ADDR[22:20] == 3'h0 && O_GLOBAL_ADDR[11:0] == addr_q[11:0] && O_REGION == 2'h1)
    else $error("ram window translation wrong");
  AST_GLOBAL_LOW: assert property (I_CPU_REQ && I_CPU_GLOBAL |=>
    O_GLOBAL_ADDR[15:0] == addr_q && O_REGION == 2'h3)
    else $error("global translation wrong");
  AST_BUS_ONE_WAIT: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=>
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("register bus answer timing wrong");

  cover property (loc && O_ALT_MAP_ACTIVE && I_CPU_ADDR[15:14] == 2'h1);
  cover property (I_CPU_REQ && I_CPU_GLOBAL);
  cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
endmodule

// ==== tb/lgam_cpu_model.sv ====
// processor core model issuing local addresses
// assumes the bench calls issue from its main sequence
`timescale 1ns/1ps
module lgam_cpu_model (
  input wire logic i_clk,
  output logic o_req,
  output logic o_global,
  output logic [15:0] o_addr
);
  initial begin
    o_req = 1'b0;
    o_global = 1'b0;
    o_addr = 16'h0000;
  end
  // one request cycle after gap idle cycles; released lines show inverted junk
  task automatic issue(input logic [15:0] a, input logic g, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_global <= g;
    o_addr <= a;
    @(posedge i_clk);
    o_req <= 1'b0;
    o_global <= ~g;
    o_addr <= ~a;
    @(negedge i_clk);
  endtask
endmodule

// ==== tb/lgam_mapper_tb.sv ====
// self-checking bench for the address mapper
// assumes a 50 MHz clock and the register map of lgam_pkg
`timescale 1ns/1ps
module lgam_mapper_tb;
  import lgam_pkg::*;
  logic clk, resetn, av_rd, av_wr, req, glb, gvalid, waitreq, alt;
  logic [7:0] av_addr;
  logic [31:0] av_wd, rdata;
  logic [3:0] av_be, cs_wait;
  logic [15:0] caddr, cs_cnt;
  logic [22:0] gaddr;
  logic [1:0] region;
  int bad_count, num_checks;
  localparam logic [5:0] ZIX [6] = '{IDX_GLOBAL_PAGE, IDX_MAP_CONTROL_ONE, IDX_MAP_CONTROL_ZERO,
    IDX_EXT_BUS_CONTROL_ZERO, IDX_RESERVED_OLD_PAGE, 6'h3F};
  localparam logic [7:0] PG [4] = '{8'h00, 8'h01, 8'hFD, 8'hFF};

  lgam_mapper #(.NUM_CS(4)) lgam_mapper_i (.I_SYS_CLK(clk), .I_RESETN(resetn),
    .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd),
    .I_AVS_BYTEENABLE(av_be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_CPU_REQ(req), .I_CPU_GLOBAL(glb), .I_CPU_ADDR(caddr), .O_GLOBAL_VALID(gvalid),
    .O_GLOBAL_ADDR(gaddr), .O_REGION(region), .O_ALT_MAP_ACTIVE(alt),
    .O_CS_STRETCH_CNT(cs_cnt), .O_CS_WAIT_EN(cs_wait));
  lgam_cpu_model lgam_cpu_model_i (.i_clk(clk), .o_req(req), .o_global(glb), .o_addr(caddr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ******************************
  // tasks
  // ******************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ack();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [3:0] be = 4'hF);
    @(posedge clk);
    av_addr <= {ix, 2'h0};
    av_wd <= {24'h000000, d};
    av_be <= be;
    av_wr <= 1'b1;
    ack();
    av_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] ix, input logic [7:0] e);
    logic [31:0] d;
    @(posedge clk);
    av_addr <= {ix, 2'h0};
    av_rd <= 1'b1;
    ack();
    d = rdata;
    av_rd <= 1'b0;
    chk($sformatf("register %h", ix), {24'h000000, e}, d);
  endtask
  task automatic xl(input logic [15:0] a, input logic g, input logic [22:0] e, input logic [1:0] r);
    lgam_cpu_model_i.issue(a, g, int'(a[1:0]));
    chk("global address", {9'h000, e}, {9'h000, gaddr});
    chk("region", {30'h0, r}, {30'h0, region});
    chk("global valid", 32'h1, {31'h0, gvalid});
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    logic [13:0] o;
    resetn = 1'b0;
    av_addr = 8'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    av_be = 4'hF;
    do_reset();
    rchk(IDX_FLASH_WINDOW_PAGE, FLASH_WINDOW_PAGE_RST);
    rchk(IDX_RAM_WINDOW_PAGE, 8'hFD);
    foreach (ZIX[i]) rchk(ZIX[i], 8'h00);
    $display("test reset values done");
    xl(16'hC000, 1'b0, 23'h7F_C000, 2'h2);
    xl(16'hFFFF, 1'b0, 23'h7F_FFFF, 2'h2);
    xl(16'h4000, 1'b0, 23'h7F_4000, 2'h2);
    xl(16'h7FFF, 1'b0, 23'h7F_7FFF, 2'h2);
    $display("test fixed flash done");
    foreach (PG[i]) begin
      o = i[0] ? 14'h3FFF : 14'h0000;
      wr(IDX_FLASH_WINDOW_PAGE, PG[i]);
      rchk(IDX_FLASH_WINDOW_PAGE, PG[i]);
      xl({2'h2, o}, 1'b0, {1'h1, PG[i], o}, 2'h2);
    end
    wr(IDX_FLASH_WINDOW_PAGE, 8'hFD);
    xl(16'h8123, 1'b0, 23'h7F_4123, 2'h2);
    wr(IDX_RESERVED_OLD_PAGE, 8'h11);
    wr(IDX_FLASH_WINDOW_PAGE, 8'h22, 4'hE);
    rchk(IDX_FLASH_WINDOW_PAGE, 8'hFD);
    rchk(IDX_RESERVED_OLD_PAGE, 8'h00);
    $display("test flash window done");
    xl(16'h1234, 1'b0, 23'h0F_D234, 2'h1);
    wr(IDX_RAM_WINDOW_PAGE, 8'hF9);
    rchk(IDX_RAM_WINDOW_PAGE, 8'hF9);
    xl(16'h1FFF, 1'b0, 23'h0F_9FFF, 2'h1);
    xl(16'h2345, 1'b0, 23'h0F_E345, 2'h1);
    xl(16'h0ABC, 1'b0, 23'h00_0ABC, 2'h0);
    wr(IDX_GLOBAL_PAGE, 8'hC0);
    xl(16'hABCD, 1'b1, 23'h40_ABCD, 2'h3);
    wr(IDX_GLOBAL_PAGE, 8'h0F);
    xl(16'h1234, 1'b1, 23'h0F_1234, 2'h3);
    $display("test ram and global done");
    wr(IDX_EXT_BUS_CONTROL_ZERO, 8'hA5);
    wr(IDX_MAP_CONTROL_ZERO, 8'hE4);
    repeat (2) @(negedge clk);
    chk("stretch count", 32'h0000_0A50, {20'h0, cs_cnt[11:0]});
    chk("wait enable", 32'h8, {28'h0, cs_wait});
    wr(IDX_MAP_CONTROL_ZERO, 8'h1B);
    repeat (2) @(negedge clk);
    chk("stretch count", 32'h0000_005A, {20'h0, cs_cnt[15:4]});
    chk("wait enable", 32'h1, {28'h0, cs_wait});
    $display("test chip selects done");
    wr(IDX_MAP_CONTROL_ONE, 8'h08);
    repeat (2) @(negedge clk);
    chk("alt map", 32'h0, {31'h0, alt});
    xl(16'h4000, 1'b0, 23'h7F_4000, 2'h2);
    wr(IDX_MAP_CONTROL_ONE, 8'h0A);
    repeat (2) @(negedge clk);
    chk("alt map", 32'h1, {31'h0, alt});
    rchk(IDX_MAP_STATUS, 8'h03);
    xl(16'h4000, 1'b0, 23'h0F_C000, 2'h1);
    xl(16'h7FFF, 1'b0, 23'h0F_FFFF, 2'h1);
    xl(16'h2000, 1'b0, 23'h0F_A000, 2'h1);
    xl(16'h3FFF, 1'b0, 23'h0F_BFFF, 2'h1);
    xl(16'h8123, 1'b0, 23'h7F_4123, 2'h2);
    wr(IDX_GLOBAL_PAGE, 8'h7F);
    xl(16'h4567, 1'b1, 23'h7F_4567, 2'h3);
    wr(IDX_MAP_CONTROL_ONE, 8'h02);
    rchk(IDX_MAP_CONTROL_ONE, 8'h0A);
    chk("alt map", 32'h1, {31'h0, alt});
    do_reset();
    wr(IDX_MAP_CONTROL_ONE, 8'h02);
    wr(IDX_MAP_CONTROL_ONE, 8'h0A);
    rchk(IDX_MAP_CONTROL_ONE, 8'h02);
    repeat (2) @(negedge clk);
    chk("alt map", 32'h0, {31'h0, alt});
    xl(16'h2000, 1'b0, 23'h0F_E000, 2'h1);
    $display("test alternative ram map done");
    summarize();
  end
endmodule

bind lgam_mapper lgam_mapper_monitor lgam_mapper_monitor_i (.I_SYS_CLK(I_SYS_CLK),
  .I_RESETN(I_RESETN), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_CPU_REQ(I_CPU_REQ), .I_CPU_GLOBAL(I_CPU_GLOBAL),
  .I_CPU_ADDR(I_CPU_ADDR), .O_GLOBAL_VALID(O_GLOBAL_VALID), .O_GLOBAL_ADDR(O_GLOBAL_ADDR),
  .O_REGION(O_REGION), .O_ALT_MAP_ACTIVE(O_ALT_MAP_ACTIVE));
